// ===== cbus_pkg.sv
// shared constants of the control bus register port
// assumes one 200 MHz clock domain
package cbus_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int REG_COUNT = 32;
	localparam logic [4:0] ADDR_MODE = 5'h00;
	localparam logic [4:0] ADDR_IRQ_COND = 5'h01;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h02;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int PARITY_ERR_BIT = 0;
	localparam int SYNC_STAGES = 2;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SETTLE_NS = 20;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== cbus_if.sv
// carrier between the port sequencer and the register file
// assumes both sides share one clock
`timescale 1ns/100ps
`default_nettype none
interface cbus_if;
	logic wr;
	logic [4:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic parity_err;
	modport port (output wr, output addr, output wdata, output parity_err, input rdata);
	modport regs (input wr, input addr, input wdata, input parity_err, output rdata);
endinterface
`default_nettype wire

// ===== cbus_regfile.sv
// thirty-two byte registers with irq condition and mask
// assumes writes arrive as one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
module cbus_regfile
	import cbus_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	cbus_if.regs bus,
	input wire logic [7:0] irq_events,
	output logic irq_pending,
	output logic [7:0] mode
);
	logic [7:0] regs [REG_COUNT];
	logic [7:0] cond_set;

	always_comb begin
		cond_set = irq_events;
		cond_set[PARITY_ERR_BIT] = irq_events[PARITY_ERR_BIT] | bus.parity_err; // [RULE_12]
	end

	// condition register: write one to clear, set wins
	always_ff @(posedge clock) begin
		for (int i = 0; i < REG_COUNT; i++) begin
			if (rst) begin
				regs[i] <= REG_RESET; // [RULE_14]
			end else if (i == int'(ADDR_IRQ_COND)) begin
				regs[i] <= (regs[i] & ~((bus.wr && bus.addr == ADDR_IRQ_COND) ? bus.wdata : 8'h00))
					| cond_set;
			end else if (bus.wr && bus.addr == 5'(i)) begin
				regs[i] <= bus.wdata; // [RULE_06]
			end
		end
	end

	assign bus.rdata = regs[bus.addr]; // [RULE_06]
	assign irq_pending = |(regs[ADDR_IRQ_COND] & ~regs[ADDR_IRQ_MASK]); // [RULE_08]
	assign mode = regs[ADDR_MODE];

	chk_reset_clear: assert property (@(posedge clock) rst |=> regs[ADDR_MODE] == 8'h00) // [RULE_14]
		else $error("mode not cleared by reset");
	chk_parity_flag: assert property (@(posedge clock) disable iff (rst)
		bus.parity_err |=> regs[ADDR_IRQ_COND][PARITY_ERR_BIT]) // [RULE_12]
		else $error("parity error flag not set");
	chk_irq_level: assert property (@(posedge clock) disable iff (rst)
		irq_pending == |(regs[ADDR_IRQ_COND] & ~regs[ADDR_IRQ_MASK])) // [RULE_08]
		else $error("interrupt level mismatch");
endmodule
`default_nettype wire

// ===== control_bus_register_port.sv
// asynchronous processor port onto a byte register file
// assumes all pins asynchronous to clock; board resolves open drains
// What this block does
// RULE_01: cycles start only while chip select low
// RULE_02: direction high reads, low writes
// RULE_03: acknowledge low until chip select released
// RULE_04: read data held while acknowledge low
// RULE_05: processor holds write data until acknowledge
// RULE_06: five-bit address selects 32 byte registers
// RULE_07: processor holds address until acknowledge
// RULE_08: interrupt pin low on unmasked pending condition
// RULE_09: parity enable switches write checking
// RULE_10: reads always drive parity bit
// RULE_11: chip select and direction treated asynchronous
// RULE_12: odd parity; bad write discarded, flag set
// RULE_13: local byte clock latches bus signals
// RULE_14: reset clears every register, stop mode
// RULE_15: release acknowledge and data before next cycle
// RULE_16: chip select through two flip-flops
`timescale 1ns/100ps
`default_nettype none
module control_bus_register_port
	import cbus_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic chip_sel_n,
	input wire logic read_not_write,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_data_in,
	output logic [7:0] reg_data_out,
	output logic reg_data_oe_n,
	input wire logic bus_parity_in,
	output logic bus_parity_out,
	output logic bus_parity_oe_n,
	input wire logic parity_check_en,
	output logic ack_n_out,
	output logic ack_n_oe_n,
	output logic irq_n_out,
	output logic irq_n_oe_n,
	input wire logic [7:0] irq_events,
	output logic [7:0] mode
);
	typedef enum logic [1:0] {
		IDLE = 2'b00,
		SETTLE = 2'b01,
		ACKED = 2'b10
	} state_e;

	function automatic logic odd_parity(input logic [7:0] d);
		return ~(^d);
	endfunction

	cbus_if bus();
	state_e state;
	logic [1:0] cs_sync;
	logic [1:0] dir_sync;
	logic [1:0] pen_sync;
	logic [4:0] addr_q [2];
	logic [7:0] data_q [2];
	logic [1:0] par_q;
	logic [3:0] settle;
	logic is_read;
	logic [7:0] rd_byte;
	logic ack_on;
	logic drive;
	logic write_ok;
	logic cs_active;

	// two-stage synchronisers for every pin except irq_events
	always_ff @(posedge clock) begin
		if (rst) begin
			cs_sync <= 2'b11;
			dir_sync <= 2'b11;
			pen_sync <= 2'b00;
			par_q <= 2'b00;
			addr_q[0] <= 5'h00;
			addr_q[1] <= 5'h00;
			data_q[0] <= 8'h00;
			data_q[1] <= 8'h00;
		end else begin
			cs_sync <= {cs_sync[0], chip_sel_n}; // [RULE_16] [RULE_11] [RULE_13]
			dir_sync <= {dir_sync[0], read_not_write}; // [RULE_11]
			pen_sync <= {pen_sync[0], parity_check_en};
			par_q <= {par_q[0], bus_parity_in};
			addr_q[0] <= reg_addr;
			addr_q[1] <= addr_q[0];
			data_q[0] <= reg_data_in;
			data_q[1] <= data_q[0];
		end
	end

	assign cs_active = ~cs_sync[1];

	// wait a few cycles so address and data have passed their synchronisers
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= IDLE;
			settle <= 4'h0;
			is_read <= 1'b0;
		end else begin
			case (state)
				IDLE: begin
					if (cs_active) begin // [RULE_01]
						state <= SETTLE;
						settle <= 4'(SETTLE_CYCLES);
					end
				end
				SETTLE: begin
					if (!cs_active) begin
						state <= IDLE;
					end else if (settle == 4'h0) begin
						state <= ACKED;
						is_read <= dir_sync[1]; // [RULE_02]
					end else begin
						settle <= settle - 4'h1;
					end
				end
				ACKED: begin
					if (!cs_active) begin
						state <= IDLE; // [RULE_15]
					end
				end
				default: state <= IDLE;
			endcase
		end
	end

	assign write_ok = !pen_sync[1] || (par_q[1] == odd_parity(data_q[1])); // [RULE_09] [RULE_12]
	assign bus.wr = (state == SETTLE) && cs_active && settle == 4'h0 && !dir_sync[1] && write_ok;
	assign bus.parity_err = (state == SETTLE) && cs_active && settle == 4'h0 && !dir_sync[1]
		&& !write_ok; // [RULE_12]
	assign bus.addr = addr_q[1]; // [RULE_06]
	assign bus.wdata = data_q[1];

	// read byte captured on entry to the acknowledged state
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_byte <= 8'h00;
		end else if (state == SETTLE && settle == 4'h0) begin
			rd_byte <= bus.rdata; // [RULE_04]
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ack_on <= 1'b0;
			drive <= 1'b0;
		end else begin
			ack_on <= (state == ACKED) && cs_active; // [RULE_03] [RULE_15]
			drive <= (state == ACKED) && cs_active && is_read; // [RULE_04] [RULE_15]
		end
	end

	assign reg_data_out = rd_byte;
	assign reg_data_oe_n = ~drive;
	assign bus_parity_out = odd_parity(rd_byte); // [RULE_10]
	assign bus_parity_oe_n = ~drive; // [RULE_10]
	assign ack_n_out = 1'b0;
	assign ack_n_oe_n = ~ack_on; // [RULE_03]

	logic irq_pending;
	logic irq_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_pending; // [RULE_08]
		end
	end
	assign irq_n_out = 1'b0;
	assign irq_n_oe_n = ~irq_q;

	cbus_regfile regfile (
		.clock(clock),
		.rst(rst),
		.bus(bus.regs),
		.irq_events(irq_events),
		.irq_pending(irq_pending),
		.mode(mode)
	);

	sequence s_acked;
		!ack_n_oe_n && cs_active;
	endsequence

	chk_ack_hold: assert property (@(posedge clock) disable iff (rst)
		s_acked ##1 cs_active |=> !ack_n_oe_n) // [RULE_03]
		else $error("acknowledge dropped while chip select low");
	chk_ack_release: assert property (@(posedge clock) disable iff (rst)
		!cs_active |-> ##[1:2] ack_n_oe_n) // [RULE_15]
		else $error("acknowledge not released");
	chk_read_stable: assert property (@(posedge clock) disable iff (rst)
		!reg_data_oe_n && $past(!reg_data_oe_n) |-> $stable(reg_data_out)) // [RULE_04]
		else $error("read data changed while driven");
	chk_read_parity: assert property (@(posedge clock) disable iff (rst)
		!bus_parity_oe_n |-> ^{reg_data_out, bus_parity_out}) // [RULE_10]
		else $error("read parity not odd");
	chk_no_idle_write: assert property (@(posedge clock) disable iff (rst)
		bus.wr |-> cs_active && !dir_sync[1]) // [RULE_01] [RULE_02]
		else $error("write outside a write cycle");
	chk_bad_parity: assert property (@(posedge clock) disable iff (rst)
		bus.wr && pen_sync[1] |-> par_q[1] == odd_parity(data_q[1])) // [RULE_12] [RULE_09]
		else $error("bad parity write accepted");
	chk_irq_pin: assert property (@(posedge clock) disable iff (rst)
		irq_pending |=> !irq_n_oe_n) // [RULE_08]
		else $error("interrupt pin not asserted");
	chk_cs_sync: assert property (@(posedge clock) disable iff (rst)
		$rose(cs_active) |-> $past(!chip_sel_n, 2)) // [RULE_16]
		else $error("chip select not synchronised");
endmodule
`default_nettype wire

// ===== host_model.sv
// processor model on the far side of the control bus pins
// assumes open drains pulled up on the board
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire logic clock,
	input wire logic ack_n_out,
	input wire logic ack_n_oe_n,
	input wire logic [7:0] reg_data_out,
	input wire logic reg_data_oe_n,
	input wire logic bus_parity_out,
	output logic chip_sel_n,
	output logic read_not_write,
	output logic [4:0] reg_addr,
	output logic [7:0] reg_data_in,
	output logic bus_parity_in
);
	wire logic ack_n = ack_n_oe_n | ack_n_out;
	initial begin
		chip_sel_n = 1'b1;
		{read_not_write, reg_addr, bus_parity_in, reg_data_in} = 15'h0000;
	end
	// req is direction, address, parity, data
	task automatic xfer(input logic [14:0] req, input int hold, output logic [8:0] rd,
		output logic ok);
		int n;
		n = 0;
		@(posedge clock);
		#1;
		{read_not_write, reg_addr, bus_parity_in, reg_data_in} = req;
		chip_sel_n = 1'b0;
		while (ack_n !== 1'b0 && n < 20) begin
			@(posedge clock);
			n++;
		end
		rd = reg_data_oe_n ? {9{1'bx}} : {bus_parity_out, reg_data_out};
		ok = n < 20;
		repeat (hold) @(posedge clock);
		if (ack_n !== 1'b0 || (req[14] && rd !== {bus_parity_out, reg_data_out}))
			ok = 1'b0;
		#1;
		chip_sel_n = 1'b1;
		// released lines stop showing the old byte
		{bus_parity_in, reg_data_in} = ~req[8:0];
		n = 0;
		while ((ack_n !== 1'b1 || reg_data_oe_n !== 1'b1) && n < 10) begin
			@(posedge clock);
			n++;
		end
		ok = ok && n < 10;
		// return off the edge so callers change inputs clear of sampling
		#1;
	endtask
endmodule
`default_nettype wire

// ===== test_control_bus_register_port.sv
// self-checking bench for the control bus register port
// assumes the processor model drives the bus pins
`timescale 1ns/100ps
`default_nettype none
module test_control_bus_register_port;
	import cbus_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic parity_check_en = 1'b1;
	logic [7:0] irq_events = 8'h00;
	logic chip_sel_n, read_not_write, bus_parity_in, bus_parity_out, reg_data_oe_n;
	logic [4:0] reg_addr;
	logic [7:0] reg_data_in, reg_data_out, mode;
	logic bus_parity_oe_n, ack_n_out, ack_n_oe_n, irq_n_out, irq_n_oe_n;
	logic [8:0] rd;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	always #2.5 clock = ~clock;
	control_bus_register_port dut_u (.clock, .rst, .chip_sel_n, .read_not_write, .reg_addr,
		.reg_data_in, .reg_data_out, .reg_data_oe_n, .bus_parity_in, .bus_parity_out,
		.bus_parity_oe_n, .parity_check_en, .ack_n_out, .ack_n_oe_n, .irq_n_out,
		.irq_n_oe_n, .irq_events, .mode);
	host_model host_u (.clock, .ack_n_out, .ack_n_oe_n, .reg_data_out, .reg_data_oe_n,
		.bus_parity_out, .chip_sel_n, .read_not_write, .reg_addr, .reg_data_in,
		.bus_parity_in);
	function automatic logic [7:0] val(input int a);
		return 8'(a * 11) ^ 8'hA5;
	endfunction
	task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic acc(input logic rnw, input logic [4:0] a, input logic [7:0] d,
		input logic p, input int hold);
		logic ok;
		host_u.xfer({rnw, a, p, d}, hold, rd, ok);
		check("handshake", 9'h001, {8'h00, ok});
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		acc(1'b0, a, d, ~^d, 0);
	endtask
	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		acc(1'b1, a, 8'h00, 1'b0, 0);
		check("read", {~^e, e}, rd);
	endtask
	task automatic irq_chk(input logic e);
		check("irq pin", {7'h00, 1'b0, e}, {7'h00, irq_n_out, irq_n_oe_n});
	endtask
	task automatic t_reset;
		check("pins", 9'h00F, {5'h00, irq_n_oe_n, ack_n_oe_n, reg_data_oe_n, bus_parity_oe_n});
		check("mode", 9'h000, {1'b0, mode});
		rchk(ADDR_IRQ_MASK, REG_RESET);
		rchk(5'h1F, REG_RESET);
		$display("reset test done");
	endtask
	task automatic t_regs;
		for (int a = 3; a < REG_COUNT; a++) wr(5'(a), val(a));
		for (int a = 3; a < REG_COUNT; a++) rchk(5'(a), val(a));
		wr(ADDR_MODE, 8'h5A);
		check("mode", 9'h05A, {1'b0, mode});
		acc(1'b1, 5'h1F, 8'h00, 1'b0, 6);
		check("held read", {~^val(31), val(31)}, rd);
		$display("register test done");
	endtask
	task automatic t_parity;
		acc(1'b0, 5'h04, 8'h3C, ^8'h3C, 0);
		rchk(5'h04, val(4));
		rchk(ADDR_IRQ_COND, 8'h01);
		irq_chk(1'b0);
		wr(ADDR_IRQ_MASK, 8'h01);
		irq_chk(1'b1);
		wr(ADDR_IRQ_MASK, 8'h00);
		wr(ADDR_IRQ_COND, 8'h01);
		irq_chk(1'b1);
		parity_check_en = 1'b0;
		acc(1'b0, 5'h04, 8'h3C, ^8'h3C, 0);
		rchk(5'h04, 8'h3C);
		rchk(ADDR_IRQ_COND, 8'h00);
		parity_check_en = 1'b1;
		$display("parity test done");
	endtask
	task automatic t_events;
		@(posedge clock);
		#1;
		irq_events = 8'h08;
		@(posedge clock);
		#1;
		irq_events = 8'h00;
		repeat (4) @(posedge clock);
		irq_chk(1'b0);
		rchk(ADDR_IRQ_COND, 8'h08);
		wr(ADDR_IRQ_COND, 8'h08);
		irq_chk(1'b1);
		$display("event test done");
	endtask
	task automatic t_rerun;
		wr(5'h07, 8'hC3);
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		check("mode", 9'h000, {1'b0, mode});
		rchk(5'h07, REG_RESET);
		$display("rerun test done");
	endtask
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock);
		#1;
		rst = 1'b0;
		t_reset;
		t_regs;
		t_parity;
		t_events;
		t_rerun;
		print_verdict;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			print_verdict;
		end
	end
endmodule
`default_nettype wire
